// >>> rtl/tsa_pkg.sv
// constants, types and register map of the temperature sensor controller
package tsa_pkg;

    // ==========================================================
    // register addresses
    localparam logic [2:0] ADDR_STATUS = 3'h0;
    localparam logic [2:0] ADDR_CONFIG = 3'h1;
    localparam logic [2:0] ADDR_TEMP = 3'h2;
    localparam logic [2:0] ADDR_ID = 3'h3;
    localparam logic [2:0] ADDR_CRIT = 3'h4;
    localparam logic [2:0] ADDR_HYST = 3'h5;
    localparam logic [2:0] ADDR_HIGH = 3'h6;
    localparam logic [2:0] ADDR_LOW = 3'h7;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_STATUS = 8'h80;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [15:0] RST_TEMP = 16'h0000;
    localparam logic [15:0] RST_CRIT = 16'h4980;
    localparam logic [7:0] RST_HYST = 8'h05;
    localparam logic [15:0] RST_HIGH = 16'h2000;
    localparam logic [15:0] RST_LOW = 16'h0500;

    // ==========================================================
    // configuration fields
    localparam int CFG_FQ_MSB = 1;
    localparam int CFG_FQ_LSB = 0;
    localparam int CFG_CT_POL = 2;
    localparam int CFG_INT_POL = 3;
    localparam int CFG_INT_MODE = 4;
    localparam int CFG_OPM_MSB = 6;
    localparam int CFG_OPM_LSB = 5;
    localparam int CFG_RES16 = 7;
    localparam logic [1:0] OPM_CONT = 2'h0;
    localparam logic [1:0] OPM_ONESHOT = 2'h1;
    localparam logic [1:0] OPM_1SPS = 2'h2;
    localparam logic [1:0] OPM_SHUT = 2'h3;

    // ==========================================================
    // status fields
    localparam int STS_RDY_N = 7;
    localparam int STS_CRIT = 6;
    localparam int STS_HIGH = 5;
    localparam int STS_LOW = 4;

    // ==========================================================
    // serial frame
    localparam int CMD_RD_BIT = 6;
    localparam int CMD_ADDR_MSB = 5;
    localparam int CMD_ADDR_LSB = 3;
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] CMD_BITS = 5'h08;
    localparam logic [4:0] DATA8_LAST = 5'h0f;
    localparam logic [4:0] DATA16_LAST = 5'h17;
    localparam logic [4:0] BIT_CNT_MAX = 5'h18;

    // ==========================================================
    // timing
    localparam int CLK_KHZ = 100000;
    localparam int FAST_MS = 6;
    localparam int CONV_MS = 240;
    localparam int SPS_CONV_MS = 60;
    localparam int SPS_IDLE_MS = 940;
    localparam int WAKE_MS = 1;
    localparam int HYST_SHIFT = 7;
    localparam logic [1:0] FQ_MAX = 2'h3;

    typedef enum logic [2:0] {
        CV_FAST,
        CV_CONV,
        CV_IDLE,
        CV_SHUT,
        CV_WAKE
    } tsa_state_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] config_r;
        logic [15:0] temp;
        logic [15:0] crit;
        logic [7:0] hyst;
        logic [15:0] high;
        logic [15:0] low;
    } tsa_regs_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] data;
    } tsa_wr_t;

endpackage

// >>> rtl/tsa_sensor_ctrl.sv
// conversion sequencing, limit alarms and serial register port of the sensor
`timescale 1ns/1ps
`default_nettype none

module tsa_sensor_ctrl
    import tsa_pkg::*;
#(
    parameter int FAST_CYC = FAST_MS * CLK_KHZ,
    parameter int CONV_CYC = CONV_MS * CLK_KHZ,
    parameter int SPS_CONV_CYC = SPS_CONV_MS * CLK_KHZ,
    parameter int SPS_IDLE_CYC = SPS_IDLE_MS * CLK_KHZ,
    parameter int WAKE_CYC = WAKE_MS * CLK_KHZ,
    // identity value is arbitrary
    parameter logic [7:0] DEVICE_ID = 8'h5a
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic din_in,
    output logic dout_out,
    output logic dout_oe_out,
    input wire logic [15:0] adc_value_in,
    output logic critical_alarm_out,
    output logic critical_alarm_oe_out,
    output logic limit_alarm_out,
    output logic limit_alarm_oe_out
);

    // ==========================================================
    // helpers
    function automatic logic is_wide(input logic [2:0] a);
        is_wide = (a == ADDR_TEMP) || (a == ADDR_CRIT) ||
                  (a == ADDR_HIGH) || (a == ADDR_LOW);
    endfunction

    function automatic logic signed [16:0] tq(input logic [15:0] v, input logic r16);
        tq = r16 ? {v[15], v} : {v[15], v[15:3], 3'h0};
    endfunction

    // ==========================================================
    // declarations
    logic spi_rst;
    logic [4:0] bcnt_q;
    logic [15:0] sh_q;
    logic cmd_rd_q;
    logic [2:0] cmd_addr_q;
    logic [7:0] cmd_w;
    logic [15:0] word_w;
    logic rd_tgl_q;
    logic [2:0] rd_addr_q;
    logic wr_tgl_q;
    tsa_wr_t wr_q;
    logic [14:0] rsh_q;
    logic dout_q;
    logic dout_oe_q;
    logic cs_s1_q, cs_s2_q;
    logic rd_s1_q, rd_s2_q, rd_s3_q;
    logic wr_s1_q, wr_s2_q, wr_s3_q;
    logic rd_evt, wr_evt, mode_wr, stat_rd;
    logic [1:0] new_mode, opm;
    tsa_regs_t pub_q;
    tsa_regs_t cur_w;
    logic [7:0] cfg_q;
    logic [15:0] crit_q, high_q, low_q, temp_q;
    logic [7:0] hyst_q;
    tsa_state_t st_q;
    logic [31:0] tmr_q;
    logic conv_done;
    logic signed [16:0] t_w, crit_w, high_w, low_w, hyst_w;
    logic over_crit, over_high, under_low, out_any, qual;
    logic ct_ok, int_ok, ct_ok_q, int_ok_q;
    logic [1:0] fq_q;
    logic ct_set, int_set, ct_clr, int_clr;
    logic ct_act_q, int_act_q;
    logic f_crit_q, f_high_q, f_low_q, rdy_n_q;
    logic ct_lvl, int_lvl;
    logic ct_oe_q, int_oe_q, ct_pin_q, int_pin_q;

    // ==========================================================
    // serial port, link clock domain
    // deselect holds the bit counter, shifters, command and dout logic in reset
    assign spi_rst = sys_rst_in | cs_n_in;
    assign cmd_w = {sh_q[6:0], din_in};
    assign word_w = {sh_q[14:0], din_in};

    always_ff @(posedge sclk_in or posedge spi_rst) begin
        if (spi_rst) begin
            bcnt_q <= 5'h00;
            sh_q <= 16'h0000;
        end else begin
            sh_q <= word_w;
            if (bcnt_q != BIT_CNT_MAX) begin
                bcnt_q <= bcnt_q + 5'h01;
            end
        end
    end

    always_ff @(posedge sclk_in or posedge spi_rst) begin
        if (spi_rst) begin
            cmd_rd_q <= 1'b0;
            cmd_addr_q <= 3'h0;
        end else if (bcnt_q == CMD_LAST) begin
            cmd_rd_q <= cmd_w[CMD_RD_BIT];
            cmd_addr_q <= cmd_w[CMD_ADDR_MSB:CMD_ADDR_LSB];
        end
    end

    // posted words survive deselect so the core can pick them up
    always_ff @(posedge sclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_tgl_q <= 1'b0;
            rd_addr_q <= 3'h0;
            wr_tgl_q <= 1'b0;
            wr_q <= '0;
        end else begin
            if (bcnt_q == CMD_LAST && cmd_w[CMD_RD_BIT]) begin
                rd_tgl_q <= ~rd_tgl_q;
                rd_addr_q <= cmd_w[CMD_ADDR_MSB:CMD_ADDR_LSB];
            end
            if (!cmd_rd_q && bcnt_q > CMD_LAST &&
                bcnt_q == (is_wide(cmd_addr_q) ? DATA16_LAST : DATA8_LAST)) begin
                wr_tgl_q <= ~wr_tgl_q;
                wr_q.addr <= cmd_addr_q;
                wr_q.data <= is_wide(cmd_addr_q) ? word_w : {8'h00, word_w[7:0]};
            end
        end
    end

    function automatic logic [15:0] rd_word(input tsa_regs_t r, input logic [2:0] a);
        case (a)
            ADDR_STATUS: rd_word = {r.status, 8'h00};
            ADDR_CONFIG: rd_word = {r.config_r, 8'h00};
            ADDR_TEMP: rd_word = r.temp;
            ADDR_ID: rd_word = {DEVICE_ID, 8'h00};
            ADDR_CRIT: rd_word = r.crit;
            ADDR_HYST: rd_word = {r.hyst, 8'h00};
            ADDR_HIGH: rd_word = r.high;
            default: rd_word = r.low;
        endcase
    endfunction

    // snapshot is frozen while selected, so it is stable on this clock
    always_ff @(negedge sclk_in or posedge spi_rst) begin
        if (spi_rst) begin
            dout_q <= 1'b0;
            dout_oe_q <= 1'b0;
            rsh_q <= 15'h0000;
        end else begin
            dout_oe_q <= 1'b1;
            if (bcnt_q == CMD_BITS && cmd_rd_q) begin
                {dout_q, rsh_q} <= rd_word(pub_q, cmd_addr_q);
            end else begin
                dout_q <= rsh_q[14];
                rsh_q <= {rsh_q[13:0], 1'b0};
            end
        end
    end

    assign dout_out = dout_q;
    assign dout_oe_out = dout_oe_q;

    // ==========================================================
    // crossings into the core clock
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            rd_s1_q <= 1'b0;
            rd_s2_q <= 1'b0;
            rd_s3_q <= 1'b0;
            wr_s1_q <= 1'b0;
            wr_s2_q <= 1'b0;
            wr_s3_q <= 1'b0;
        end else begin
            cs_s1_q <= cs_n_in;
            cs_s2_q <= cs_s1_q;
            rd_s1_q <= rd_tgl_q;
            rd_s2_q <= rd_s1_q;
            rd_s3_q <= rd_s2_q;
            wr_s1_q <= wr_tgl_q;
            wr_s2_q <= wr_s1_q;
            wr_s3_q <= wr_s2_q;
        end
    end

    assign rd_evt = rd_s2_q ^ rd_s3_q;
    assign wr_evt = wr_s2_q ^ wr_s3_q;
    assign stat_rd = rd_evt && rd_addr_q == ADDR_STATUS;
    assign mode_wr = wr_evt && wr_q.addr == ADDR_CONFIG;
    assign new_mode = wr_q.data[CFG_OPM_MSB:CFG_OPM_LSB];
    assign opm = cfg_q[CFG_OPM_MSB:CFG_OPM_LSB];

    assign cur_w = '{status: {rdy_n_q, f_crit_q, f_high_q, f_low_q, 4'h0},
                     config_r: cfg_q, temp: temp_q, crit: crit_q,
                     hyst: hyst_q, high: high_q, low: low_q};

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pub_q <= '{status: RST_STATUS, config_r: RST_CONFIG, temp: RST_TEMP,
                       crit: RST_CRIT, hyst: RST_HYST, high: RST_HIGH, low: RST_LOW};
        end else if (cs_s2_q) begin
            pub_q <= cur_w;
        end
    end

    // ==========================================================
    // writable registers
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_q <= RST_CONFIG;
            crit_q <= RST_CRIT;
            hyst_q <= RST_HYST;
            high_q <= RST_HIGH;
            low_q <= RST_LOW;
        end else if (wr_evt) begin
            case (wr_q.addr)
                ADDR_CONFIG: cfg_q <= wr_q.data[7:0];
                ADDR_CRIT: crit_q <= wr_q.data;
                ADDR_HYST: hyst_q <= wr_q.data[7:0];
                ADDR_HIGH: high_q <= wr_q.data;
                ADDR_LOW: low_q <= wr_q.data;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // conversion sequencer, core clock only
    assign conv_done = (st_q == CV_FAST || st_q == CV_CONV) && tmr_q == 32'h0;

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q <= CV_FAST;
            tmr_q <= 32'(FAST_CYC - 1);
        end else if (mode_wr) begin
            unique case (new_mode)
                OPM_CONT: begin
                    if (st_q == CV_SHUT) begin
                        st_q <= CV_WAKE;
                        tmr_q <= 32'(WAKE_CYC - 1);
                    end else if (st_q == CV_IDLE) begin
                        st_q <= CV_CONV;
                        tmr_q <= 32'(CONV_CYC - 1);
                    end
                end
                OPM_ONESHOT: begin
                    st_q <= CV_CONV;
                    tmr_q <= 32'(CONV_CYC - 1);
                end
                OPM_1SPS: begin
                    st_q <= CV_CONV;
                    tmr_q <= 32'(SPS_CONV_CYC - 1);
                end
                OPM_SHUT: begin
                    st_q <= CV_SHUT;
                    tmr_q <= 32'h0;
                end
            endcase
        end else if (tmr_q != 32'h0) begin
            tmr_q <= tmr_q - 32'h1;
        end else begin
            unique case (st_q)
                CV_FAST, CV_CONV: begin
                    unique case (opm)
                        OPM_CONT: begin
                            st_q <= CV_CONV;
                            tmr_q <= 32'(CONV_CYC - 1);
                        end
                        OPM_1SPS: begin
                            st_q <= CV_IDLE;
                            tmr_q <= 32'(SPS_IDLE_CYC - 1);
                        end
                        OPM_ONESHOT, OPM_SHUT: st_q <= CV_SHUT;
                    endcase
                end
                CV_IDLE: begin
                    st_q <= CV_CONV;
                    tmr_q <= 32'(SPS_CONV_CYC - 1);
                end
                CV_WAKE: begin
                    st_q <= CV_CONV;
                    tmr_q <= 32'(CONV_CYC - 1);
                end
                CV_SHUT: st_q <= CV_SHUT;
            endcase
        end
    end

    // ==========================================================
    // limit comparison
    // 13-bit mode drops the three flag positions on both sides
    assign t_w = tq(adc_value_in, cfg_q[CFG_RES16]);
    assign crit_w = tq(crit_q, cfg_q[CFG_RES16]);
    assign high_w = tq(high_q, cfg_q[CFG_RES16]);
    assign low_w = tq(low_q, cfg_q[CFG_RES16]);
    assign hyst_w = {6'h00, hyst_q[3:0], 7'h00};
    assign over_crit = t_w > crit_w;
    assign over_high = t_w > high_w;
    assign under_low = t_w < low_w;
    assign out_any = over_crit | over_high | under_low;
    assign ct_ok = t_w < crit_w - hyst_w;
    assign int_ok = (t_w < high_w - hyst_w) && (t_w > low_w + hyst_w);
    assign qual = out_any && (fq_q >= cfg_q[CFG_FQ_MSB:CFG_FQ_LSB]);

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fq_q <= 2'h0;
        end else if (conv_done) begin
            if (!out_any) begin
                fq_q <= 2'h0;
            end else if (fq_q != FQ_MAX) begin
                fq_q <= fq_q + 2'h1;
            end
        end
    end

    // ==========================================================
    // result and status
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            temp_q <= RST_TEMP;
            ct_ok_q <= 1'b1;
            int_ok_q <= 1'b1;
        end else if (conv_done) begin
            ct_ok_q <= ct_ok;
            int_ok_q <= int_ok;
            if (cfg_q[CFG_RES16]) begin
                temp_q <= adc_value_in;
            end else begin
                temp_q <= {adc_value_in[15:3], over_crit, over_high, under_low};
            end
        end
    end

    // hardware set beats a clear in the same cycle
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            f_crit_q <= 1'b0;
            f_high_q <= 1'b0;
            f_low_q <= 1'b0;
            rdy_n_q <= RST_STATUS[STS_RDY_N];
        end else begin
            if (ct_set) begin
                f_crit_q <= 1'b1;
            end else if (stat_rd || (conv_done && ct_ok)) begin
                f_crit_q <= 1'b0;
            end
            if (conv_done && qual && over_high) begin
                f_high_q <= 1'b1;
            end else if (stat_rd || (conv_done && int_ok)) begin
                f_high_q <= 1'b0;
            end
            if (conv_done && qual && under_low) begin
                f_low_q <= 1'b1;
            end else if (stat_rd || (conv_done && int_ok)) begin
                f_low_q <= 1'b0;
            end
            if (conv_done) begin
                rdy_n_q <= 1'b0;
            end else if ((rd_evt && rd_addr_q == ADDR_TEMP) ||
                         (mode_wr && (new_mode == OPM_ONESHOT || new_mode == OPM_1SPS))) begin
                rdy_n_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // alarm state
    assign ct_set = conv_done && qual && over_crit;
    assign int_set = conv_done && qual && (over_high || under_low);

    always_comb begin
        if (cfg_q[CFG_INT_MODE]) begin
            ct_clr = rd_evt;
            int_clr = rd_evt;
        end else if (opm == OPM_ONESHOT) begin
            ct_clr = mode_wr && ct_ok_q;
            int_clr = mode_wr && int_ok_q;
        end else begin
            ct_clr = conv_done && ct_ok;
            int_clr = conv_done && int_ok;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ct_act_q <= 1'b0;
            int_act_q <= 1'b0;
        end else begin
            if (ct_set) begin
                ct_act_q <= 1'b1;
            end else if (ct_clr) begin
                ct_act_q <= 1'b0;
            end
            if (int_set) begin
                int_act_q <= 1'b1;
            end else if (int_clr) begin
                int_act_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // open-drain pins: enable pulls the wire low
    assign ct_lvl = ct_act_q ? cfg_q[CFG_CT_POL] : ~cfg_q[CFG_CT_POL];
    assign int_lvl = int_act_q ? cfg_q[CFG_INT_POL] : ~cfg_q[CFG_INT_POL];

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ct_oe_q <= 1'b0;
            int_oe_q <= 1'b0;
            ct_pin_q <= 1'b0;
            int_pin_q <= 1'b0;
        end else begin
            ct_oe_q <= ~ct_lvl;
            int_oe_q <= ~int_lvl;
            ct_pin_q <= 1'b0;
            int_pin_q <= 1'b0;
        end
    end

    assign critical_alarm_out = ct_pin_q;
    assign critical_alarm_oe_out = ct_oe_q;
    assign limit_alarm_out = int_pin_q;
    assign limit_alarm_oe_out = int_oe_q;

endmodule // tsa_sensor_ctrl

`default_nettype wire

// >>> verif/tsa_sensor_ctrl_chk.sv
// port checker of the sensor controller
`timescale 1ns/1ps
`default_nettype none
module tsa_sensor_ctrl_chk
    import tsa_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic din_in,
    input wire logic dout_out,
    input wire logic dout_oe_out,
    input wire logic [15:0] adc_value_in,
    input wire logic critical_alarm_out,
    input wire logic critical_alarm_oe_out,
    input wire logic limit_alarm_out,
    input wire logic limit_alarm_oe_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    // valid only while the reset limits and polarities stay
    function automatic logic ct_hit(input logic [15:0] v);
        return $signed(v) > $signed(RST_CRIT);
    endfunction
    function automatic logic lim_hit(input logic [15:0] v);
        return $signed(v) > $signed(RST_HIGH) || $signed(v) < $signed(RST_LOW);
    endfunction
    // ========
    // serial port
    sequence s_sel_fall; $fell(cs_n_in); endsequence
    sequence s_quiet; !dout_oe_out [*3]; endsequence
    property p_frame_quiet; s_sel_fall |-> s_quiet; endproperty
    a_frame_quiet: assert property (p_frame_quiet) else $error("dout early");
    property p_desel; cs_n_in |-> !dout_oe_out; endproperty
    a_desel: assert property (p_desel) else $error("dout while idle");
    property p_oe_sel; $rose(dout_oe_out) |-> !cs_n_in; endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("dout unselected");
    property p_oe_stand; dout_oe_out && !cs_n_in |=> dout_oe_out || cs_n_in; endproperty
    a_oe_stand: assert property (p_oe_stand) else $error("dout dropped");
    // ========
    // alarms
    property p_rst_rel;
        $fell(sys_rst_in) |-> !critical_alarm_oe_out && !limit_alarm_oe_out;
    endproperty
    a_rst_rel: assert property (p_rst_rel) else $error("alarm at reset");
    property p_open_drain; !critical_alarm_out && !limit_alarm_out; endproperty
    a_open_drain: assert property (p_open_drain) else $error("alarm drives high");
    property p_ct_set;
        $rose(critical_alarm_oe_out) |-> ct_hit($past(adc_value_in))
            || ct_hit($past(adc_value_in, 2)) || ct_hit($past(adc_value_in, 3));
    endproperty
    a_ct_set: assert property (p_ct_set) else $error("critical without cause");
    property p_lim_set;
        $rose(limit_alarm_oe_out) |-> lim_hit($past(adc_value_in))
            || lim_hit($past(adc_value_in, 2)) || lim_hit($past(adc_value_in, 3));
    endproperty
    a_lim_set: assert property (p_lim_set) else $error("limit without cause");
endmodule // tsa_sensor_ctrl_chk
bind tsa_sensor_ctrl tsa_sensor_ctrl_chk u_chk (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .sclk_in(sclk_in), .cs_n_in(cs_n_in), .din_in(din_in), .dout_out(dout_out),
    .dout_oe_out(dout_oe_out), .adc_value_in(adc_value_in),
    .critical_alarm_out(critical_alarm_out), .critical_alarm_oe_out(critical_alarm_oe_out),
    .limit_alarm_out(limit_alarm_out), .limit_alarm_oe_out(limit_alarm_oe_out));
`default_nettype wire

// >>> verif/tsa_host.sv
// host model driving serial frames
`timescale 1ns/1ps
`default_nettype none
module tsa_host (
    output logic sclk_out,
    output logic cs_n_out,
    output logic din_out,
    input wire logic dout_in,
    input wire logic dout_oe_in
);
    // ========
    // frame engine, 6 ns link clock, still between frames
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        din_out = 1'b0;
    end
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int nb,
                        output logic [15:0] rd);
        logic [23:0] s;
        s = (nb == 16) ? {cmd, wd} : {cmd, wd[7:0], 8'h00};
        rd = 16'h0000;
        cs_n_out = 1'b0;
        #45;
        for (int i = 0; i < 8 + nb; i++) begin
            din_out = s[23 - i];
            #3 sclk_out = 1'b1;
            if (i >= 8) rd = {rd[14:0], dout_oe_in ? dout_in : 1'bx};
            #3 sclk_out = 1'b0;
        end
        #3 cs_n_out = 1'b1;
        // inverse level so a stale bit cannot pass
        din_out = ~din_out;
        #45;
    endtask
endmodule // tsa_host
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench of the sensor controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tsa_pkg::*;
    localparam int CONV = 240;
    localparam logic [7:0] ID = 8'h3c; // arbitrary identity value
    logic clock_in;
    logic sys_rst_in;
    logic [15:0] adc;
    logic [15:0] rd;
    logic sclk, cs_n, din, dout, dout_oe, ct, ct_oe, lim, lim_oe;
    int errors = 0;
    int n_checks = 0;
    tsa_sensor_ctrl #(.FAST_CYC(60), .CONV_CYC(CONV), .SPS_CONV_CYC(60), .SPS_IDLE_CYC(94),
        .WAKE_CYC(10), .DEVICE_ID(ID)) dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din), .dout_out(dout), .dout_oe_out(dout_oe),
        .adc_value_in(adc), .critical_alarm_out(ct), .critical_alarm_oe_out(ct_oe),
        .limit_alarm_out(lim), .limit_alarm_oe_out(lim_oe));
    tsa_host host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout),
        .dout_oe_in(dout_oe));
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // ========
    // reference model and tasks
    function automatic logic [15:0] exp_temp(input logic [15:0] a, input logic r16);
        int v;
        v = $signed(a & 16'hfff8);
        if (r16) return a;
        return {a[15:3], v > $signed(RST_CRIT), v > $signed(RST_HIGH), v < $signed(RST_LOW)};
    endfunction
    function automatic logic [15:0] alarms();
        return {14'h0000, ct_oe, lim_oe};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task automatic acc(input logic rd_n, input logic [2:0] a, input logic [15:0] d);
        host.xfer({1'b0, rd_n, a, 3'h0}, d, (a inside {3'h2, 3'h4, 3'h6, 3'h7}) ? 16 : 8, rd);
        wait_cyc(5);
    endtask
    task automatic rdchk(input logic [2:0] a, input logic [15:0] e);
        acc(1'b1, a, 16'h0000);
        chk(rd, e);
    endtask
    task automatic setadc(input logic [15:0] v, input int n);
        @(negedge clock_in) adc = v;
        wait_cyc(n);
    endtask
    task automatic finish_test;
        if (errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #200us;
        errors++;
        finish_test();
    end
    // ========
    // scenarios
    initial begin
        logic [15:0] rv [8];
        void'($urandom(87));
        sys_rst_in = 1'b1;
        adc = 16'h1000;
        rv = '{16'(RST_STATUS), 16'(RST_CONFIG), RST_TEMP, 16'(ID), RST_CRIT,
            16'(RST_HYST), RST_HIGH, RST_LOW};
        repeat (6) @(posedge clock_in);
        @(negedge clock_in) sys_rst_in = 1'b0;
        wait_cyc(1);
        chk(alarms(), 16'h0000);
        for (int a = 0; a < 8; a++) rdchk(3'(a), rv[a]);
        rdchk(3'h2, exp_temp(16'h1000, 1'b0));
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, 3'h1, {8'h00, !i[0], 7'h00});
            setadc(16'($urandom), CONV + 30);
            rdchk(3'h2, exp_temp(adc, !i[0]));
        end
        setadc(16'h1000, 2 * CONV);
        chk(alarms(), 16'h0000);
        setadc(16'h3000, CONV + 30);
        chk(alarms(), 16'h0001);
        setadc(16'h5000, CONV + 30);
        chk(alarms(), 16'h0003);
        setadc(16'hf000, CONV + 30);
        chk(alarms(), 16'h0001);
        setadc(16'h1000, CONV + 30);
        chk(alarms(), 16'h0000);
        // interrupt mode first, shutdown before the read, so no fresh conversion re-arms the alarm
        acc(1'b0, 3'h1, 16'h0010);
        setadc(16'h3000, CONV + 30);
        acc(1'b0, 3'h1, 16'h0070);
        chk(alarms(), 16'h0001);
        rdchk(3'h1, 16'h0070);
        chk(alarms(), 16'h0000);
        setadc(16'h5000, 5);
        acc(1'b0, 3'h1, 16'h0020);
        wait_cyc(CONV + 30);
        chk(alarms(), 16'h0003);
        setadc(16'h0800, 5);
        acc(1'b0, 3'h1, 16'h0020);
        wait_cyc(CONV + 30);
        rdchk(3'h2, exp_temp(16'h0800, 1'b0));
        setadc(16'h0900, 2 * CONV);
        rdchk(3'h2, exp_temp(16'h0800, 1'b0));
        acc(1'b0, 3'h1, 16'h0020);
        chk(alarms(), 16'h0000);
        wait_cyc(CONV + 30);
        rdchk(3'h2, exp_temp(16'h0900, 1'b0));
        acc(1'b0, 3'h1, 16'h0000);
        setadc(16'h0a00, CONV + 40);
        rdchk(3'h2, exp_temp(16'h0a00, 1'b0));
        acc(1'b0, 3'h1, 16'h0040);
        setadc(16'h0b00, 2 * 154 + 30);
        rdchk(3'h2, exp_temp(16'h0b00, 1'b0));
        finish_test();
    end
endmodule // testbench
`default_nettype wire
